// file: rtl/psl_tx.sv
// Transmitting end: FIFO plus serializer driving four lanes and a forwarded clock.
// Assumes the pixel clock and pixel bits arrive asynchronously and run slower than
// one frame of seven slots; the FIFO absorbs bursts.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Simple synchronous FIFO with valid/ready on both sides
module psl_fifo #(
	parameter int W     = 28,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         flush_i,
	// Fill side
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	// Drain side
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);

	// Pointer state, one extra bit tells full from empty
	typedef struct packed {
		logic [AW:0] wr;                       // Write pointer
		logic [AW:0] rd;                       // Read pointer
	} psl_fifo_st_type;

	psl_fifo_st_type st_r;                   // Registered pointers
	psl_fifo_st_type st_nxt;                 // Next pointers
	logic [W-1:0]    mem [DEPTH];            // Storage
	logic            push;                   // Word accepted
	logic            pop;                    // Word taken

	assign in_ready_o  = (st_r.wr ^ st_r.rd) != {1'b1, {AW{1'b0}}};
	assign out_valid_o = st_r.wr != st_r.rd;
	assign out_data_o  = mem[st_r.rd[AW-1:0]];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	// Pointer update; flush empties the queue
	always_comb
	begin
		st_nxt = st_r;
		if (push)
			st_nxt.wr = st_r.wr + 1'b1;
		if (pop)
			st_nxt.rd = st_r.rd + 1'b1;
		if (flush_i)
			st_nxt.rd = st_nxt.wr;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// Storage has no reset: contents are only read behind valid
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[st_r.wr[AW-1:0]] <= in_data_i;
	end
endmodule : psl_fifo

////////////////////////////////////////////////////////////////////////////////
module psl_tx #(
	parameter int WORD_W = psl_pkg::WORD_W,
	parameter int DEPTH  = psl_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Controller side
	input  wire logic              power_down_n_i,
	input  wire logic              pixel_strobe_clock_in_i,
	input  wire logic [WORD_W-1:0] parallel_pixel_inputs_i,
	output logic                   pixel_ready_o,
	// Link side
	psl_link_if.tx                 link
);
	// Serializer states, Gray along idle -> send
	typedef enum logic [1:0] {
		TX_IDLE = 2'h0,
		TX_SEND = 2'h1
	} psl_tx_state_type;

	// Whole module state
	typedef struct packed {
		logic [1:0]            pclk_s;        // Pixel clock synchronizer
		logic                  pclk_q;        // Synced clock, one cycle later
		logic [1:0]            pd_s;          // Power-down synchronizer
		logic [WORD_W-1:0]     d_s1;          // Pixel bits, first stage
		logic [WORD_W-1:0]     d_s2;          // Pixel bits, second stage
		psl_tx_state_type      state;         // Serializer state
		logic [2:0]            slot;          // Current slot
		logic [3:0]            cnt;           // Cycles within slot
		logic [WORD_W-1:0]     word;          // Word on the wire
		logic [psl_pkg::LANES-1:0] lane;      // Lane levels
		logic                  fclk;          // Forwarded clock level
		logic                  oe;            // Drivers enabled
	} psl_tx_st_type;

	psl_tx_st_type     st_r;                 // Registered state
	psl_tx_st_type     st_nxt;               // Next state
	logic              fall;                 // Falling pixel clock seen
	logic              pd_on;                // Powered (synced, high = running)
	logic              f_valid;              // FIFO has a word
	logic              f_pop;                // Take a word now
	logic [WORD_W-1:0] f_data;               // Head word

	assign pd_on = st_r.pd_s[1];
	assign fall  = st_r.pclk_q & ~st_r.pclk_s[1];    // see [R5]

	// Buffer between capture and serializer; power-down drops queued words
	psl_fifo #(
		.W     (WORD_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.flush_i     (~pd_on),
		.in_valid_i  (fall & pd_on),                   // see [R1]
		.in_ready_o  (pixel_ready_o),
		.in_data_i   (st_r.d_s2),
		.out_valid_o (f_valid),
		.out_ready_i (f_pop),
		.out_data_o  (f_data)
	);

	// Lane level for a slot of a word
	function automatic logic [psl_pkg::LANES-1:0] slot_bits(
		input logic [WORD_W-1:0] w,
		input int                s
	);
		logic [psl_pkg::LANES-1:0] b;
		b = '0;
		for (int l = 0; l < psl_pkg::LANES; l++)
			b[l] = w[psl_pkg::lane_bit(l, s)];         // see [R18]
		return b;
	endfunction : slot_bits

	// Capture, serialize and power control
	always_comb
	begin
		st_nxt        = st_r;
		f_pop         = 1'b0;
		st_nxt.pclk_s = {st_r.pclk_s[0], pixel_strobe_clock_in_i};
		st_nxt.pclk_q = st_r.pclk_s[1];
		st_nxt.pd_s   = {st_r.pd_s[0], power_down_n_i};
		st_nxt.d_s1   = parallel_pixel_inputs_i;        // see [R2]
		st_nxt.d_s2   = st_r.d_s1;
		st_nxt.oe     = pd_on;                        // see [R7] [R17]
		case (st_r.state)
			TX_IDLE:
			begin
				// Clock lane rests low between frames
				st_nxt.fclk = 1'b0;
				if (pd_on && f_valid)
				begin
					f_pop        = 1'b1;
					st_nxt.word  = f_data;
					st_nxt.slot  = 3'h0;
					st_nxt.cnt   = 4'h0;
					st_nxt.lane  = slot_bits(f_data, 0);
					st_nxt.fclk  = 1'b1;                   // see [R4] [R16]
					st_nxt.state = TX_SEND;
				end
			end
			TX_SEND:
			begin
				if (st_r.cnt != 4'(psl_pkg::SLOT_CYCLES - 1))
					st_nxt.cnt = st_r.cnt + 4'h1;
				else if (st_r.slot != 3'(psl_pkg::SLOTS - 1))
				begin
					// Next slot of the same word
					st_nxt.cnt  = 4'h0;
					st_nxt.slot = st_r.slot + 3'h1;
					st_nxt.lane = slot_bits(st_r.word, int'(st_nxt.slot));  // see [R6]
					st_nxt.fclk = psl_pkg::fwd_level(int'(st_nxt.slot));    // see [R16]
				end
				else if (f_valid)
				begin
					// Back to back: next word starts without a gap
					f_pop       = 1'b1;
					st_nxt.word = f_data;
					st_nxt.cnt  = 4'h0;
					st_nxt.slot = 3'h0;
					st_nxt.lane = slot_bits(f_data, 0);
					st_nxt.fclk = 1'b1;
				end
				else
				begin
					st_nxt.fclk  = 1'b0;
					st_nxt.lane  = '0;
					st_nxt.state = TX_IDLE;
				end
			end
			default:
				st_nxt.state = TX_IDLE;
		endcase
		// Power-down aborts any frame at once
		if (!pd_on)
		begin
			st_nxt.state = TX_IDLE;
			st_nxt.fclk  = 1'b0;
			st_nxt.lane  = '0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// Differential pairs straight from flops
	assign link.serial_lane_pos     = st_r.lane;            // see [R3]
	assign link.serial_lane_neg     = ~st_r.lane;
	assign link.serial_lane_oe      = st_r.oe;
	assign link.forwarded_clock_pos = st_r.fclk;
	assign link.forwarded_clock_neg = ~st_r.fclk;
	assign link.forwarded_clock_oe  = st_r.oe;
endmodule : psl_tx

`default_nettype wire

// file: rtl/psl_pkg.sv
// Shared constants for the serial pixel link: lane geometry, bit map, timing counts.
// Assumes both ends run from one 50 MHz clock, clk_i, with a synchronous reset.
// What this block does
// [R1] Transmitter takes 28 parallel bits per pixel
// [R2] Four control lines: line, frame, valid, spare
// [R3] Serial data leaves on exactly four lanes
// [R4] Pixel clock forwarded on its own lane
// [R5] Inputs captured on falling pixel clock edge
// [R6] Seven bit slots per lane per pixel
// [R7] Power-down low floats all transmitter outputs; pixel_ready_o stays driven, high, instead of floating
// [R8] Receiver deserializes four lanes plus clock lane
// [R9] Receiver outputs 28 bits, same layout
// [R10] Recovered clock falling edge marks valid data
// [R11] Receiver power-down holds every output steady; lock_ok_o drops low instead of holding
// [R12] Receiver enters power-down within one microsecond
// [R13] User waits 10 ms for lock
// [R14] Sync and enable suggested on bits 24-26
// [R15] Bit 23 reserved, bit 27 red six
// [R16] Slot k starts k sevenths after edge
// [R17] Transmitter floats within 100 ns of power-down
// [R18] Both ends share one fixed bit map
`default_nettype none

package psl_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Link geometry
	localparam int LANES      = 4;                 // Data lanes
	localparam int SLOTS      = 7;                 // Bit slots per pixel period
	localparam int WORD_W     = 28;                // Parallel bits per pixel
	localparam int FWD_HIGH   = 4;                 // Slots the forwarded clock is high
	localparam int FIFO_DEPTH = 32;                // Words buffered in the transmitter

	// Suggested placement of control and odd bits
	localparam int BIT_RESERVED  = 23;             // Reserved bit
	localparam int BIT_LINE_SYNC = 24;             // line_sync
	localparam int BIT_FRAME_SYN = 25;             // frame_sync
	localparam int BIT_DATA_EN   = 26;             // display_data_enable
	localparam int BIT_RED6      = 27;             // Red bit six

	////////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_HZ        = 50_000_000;    // System clock rate
	localparam int CLK_PERIOD_NS = 20;             // System clock period
	localparam int SLOT_CYCLES   = 1;              // Clock cycles per bit slot
	localparam int TX_PD_MAX_NS  = 100;            // Transmitter float deadline
	localparam int TX_PD_CYCLES  = TX_PD_MAX_NS / CLK_PERIOD_NS;
	localparam int RX_PD_MAX_NS  = 1000;           // Receiver power-down deadline
	localparam int RX_PD_CYCLES  = RX_PD_MAX_NS / CLK_PERIOD_NS;
	localparam int LOCK_MS       = 10;             // Lock interval after wake
	localparam int LOCK_CYCLES   = LOCK_MS * (CLK_HZ / 1000);
	localparam int RCLK_HIGH     = 3;              // Recovered clock high time, cycles

	////////////////////////////////////////////////////////////////////////////////
	// Fixed map of lane and slot to parallel bit, used by both ends
	function automatic int lane_bit(input int lane, input int slot);
		return lane * SLOTS + slot;                  // see [R18]
	endfunction : lane_bit

	// Forwarded clock level for a slot: high first, low last
	function automatic logic fwd_level(input int slot);
		return (slot < FWD_HIGH);                    // see [R16]
	endfunction : fwd_level

endpackage : psl_pkg

`default_nettype wire

// file: rtl/psl_link_if.sv
// Carrier for the serial link between transmitter and receiver.
// Output enables are high while the transmitter drives; the receiver reads a floated
// pair as low.
`default_nettype none

interface psl_link_if;
	logic [psl_pkg::LANES-1:0] serial_lane_pos;       // Data lanes, true side
	logic [psl_pkg::LANES-1:0] serial_lane_neg;       // Data lanes, complement side
	logic                      serial_lane_oe;        // Lanes driven
	logic                      forwarded_clock_pos;   // Clock lane, true side
	logic                      forwarded_clock_neg;   // Clock lane, complement side
	logic                      forwarded_clock_oe;    // Clock lane driven

	// Transmitting end
	modport tx (
		output serial_lane_pos,
		output serial_lane_neg,
		output serial_lane_oe,
		output forwarded_clock_pos,
		output forwarded_clock_neg,
		output forwarded_clock_oe
	);

	// Receiving end
	modport rx (
		input  serial_lane_pos,
		input  serial_lane_neg,
		input  serial_lane_oe,
		input  forwarded_clock_pos,
		input  forwarded_clock_neg,
		input  forwarded_clock_oe
	);
endinterface : psl_link_if

`default_nettype wire

// file: rtl/psl_rx.sv
// Receiving end: deserializer rebuilding 28 parallel bits and a strobe clock.
// Assumes the transmitter runs from the same clk_i, so one slot per cycle is safe;
// the forwarded clock stands low between frames.
`default_nettype none

module psl_rx #(
	parameter int WORD_W      = psl_pkg::WORD_W,
	parameter int LOCK_CYCLES = psl_pkg::LOCK_CYCLES
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Panel side
	input  wire logic              power_down_n_i,
	output logic [WORD_W-1:0]      parallel_pixel_outputs_o,
	output logic                   pixel_strobe_clock_out_o,
	output logic                   lock_ok_o,
	// Link side
	psl_link_if.rx                 link
);
	// Deserializer states, Gray along wait -> shift
	typedef enum logic [1:0] {
		RX_WAIT  = 2'h0,
		RX_SHIFT = 2'h1
	} psl_rx_state_type;

	// Whole module state
	typedef struct packed {
		logic [psl_pkg::LANES-1:0] lane_s1;   // Lane synchronizer, first
		logic [psl_pkg::LANES-1:0] lane_s2;   // Lane synchronizer, second
		logic [psl_pkg::LANES-1:0] lane_q;    // Lanes aligned with state
		logic [1:0]            clk_s;         // Clock lane synchronizer
		logic                  clk_q;         // Synced clock, one cycle later
		logic [1:0]            pd_s;          // Power-down synchronizer
		psl_rx_state_type      state;         // Deserializer state
		logic [2:0]            slot;          // Slot being sampled
		logic [3:0]            cnt;           // Cycles within slot
		logic [WORD_W-1:0]     word;          // Word being assembled
		logic [WORD_W-1:0]     dout;          // Parallel output
		logic                  rclk;          // Recovered strobe clock
		logic [3:0]            hcnt;          // Strobe high time
		logic [31:0]           lock_cnt;      // Lock interval counter
		logic                  locked;        // Lock interval over
	} psl_rx_st_type;

	psl_rx_st_type st_r;                     // Registered state
	psl_rx_st_type st_nxt;                   // Next state
	logic          rise;                     // Frame start seen
	logic          pd_on;                    // Powered (synced)

	assign pd_on = st_r.pd_s[1];
	assign rise  = ~st_r.clk_q & st_r.clk_s[1];         // see [R16]

	// Sample lanes, rebuild word, drive strobe
	always_comb
	begin
		st_nxt         = st_r;
		// A floated or broken pair reads as low, so a dead link never looks like a frame
		st_nxt.lane_s1 = link.serial_lane_pos & ~link.serial_lane_neg
			& {psl_pkg::LANES{link.serial_lane_oe}};
		st_nxt.lane_s2 = st_r.lane_s1;
		st_nxt.lane_q  = st_r.lane_s2;
		st_nxt.clk_s   = {st_r.clk_s[0],
			link.forwarded_clock_pos & ~link.forwarded_clock_neg & link.forwarded_clock_oe};
		st_nxt.clk_q   = st_r.clk_s[1];
		st_nxt.pd_s    = {st_r.pd_s[0], power_down_n_i};
		// Strobe falls after its high time; data already stable
		if (st_r.rclk)
		begin
			if (st_r.hcnt == 4'(psl_pkg::RCLK_HIGH - 1))
				st_nxt.rclk = 1'b0;                       // see [R10]
			else
				st_nxt.hcnt = st_r.hcnt + 4'h1;
		end
		case (st_r.state)
			RX_WAIT:
			begin
				if (rise)
				begin
					st_nxt.state = RX_SHIFT;
					st_nxt.slot  = 3'h0;
					st_nxt.cnt   = 4'h0;
				end
			end
			RX_SHIFT:
			begin
				// Sample at slot middle; lane_q lags the edge detect by one
				if (st_r.cnt == 4'(psl_pkg::SLOT_CYCLES / 2))
					for (int l = 0; l < psl_pkg::LANES; l++)
						st_nxt.word[psl_pkg::lane_bit(l, int'(st_r.slot))] =
							st_r.lane_q[l];                     // see [R8] [R18]
				if (st_r.cnt != 4'(psl_pkg::SLOT_CYCLES - 1))
					st_nxt.cnt = st_r.cnt + 4'h1;
				else if (st_r.slot != 3'(psl_pkg::SLOTS - 1))
				begin
					st_nxt.cnt  = 4'h0;
					st_nxt.slot = st_r.slot + 3'h1;
				end
				else
				begin
					// Word complete: publish and raise strobe
					st_nxt.dout  = st_nxt.word;                // see [R9] [R2]
					st_nxt.rclk  = 1'b1;
					st_nxt.hcnt  = 4'h0;
					st_nxt.cnt   = 4'h0;
					st_nxt.slot  = 3'h0;
					st_nxt.state = rise ? RX_SHIFT : RX_WAIT;
				end
			end
			default:
				st_nxt.state = RX_WAIT;
		endcase
		// Lock interval counts from wake-up
		if (!st_r.locked)
		begin
			if (st_r.lock_cnt == 32'(LOCK_CYCLES - 1))
				st_nxt.locked = 1'b1;                     // see [R13]
			else
				st_nxt.lock_cnt = st_r.lock_cnt + 32'h1;
		end
		// Power-down: freeze outputs, stop decoding, restart lock
		if (!pd_on)
		begin
			st_nxt.state    = RX_WAIT;
			st_nxt.dout     = st_r.dout;                 // see [R11] [R12]
			st_nxt.rclk     = st_r.rclk;
			st_nxt.hcnt     = st_r.hcnt;
			st_nxt.locked   = 1'b0;
			st_nxt.lock_cnt = 32'h0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// Outputs from flops
	assign parallel_pixel_outputs_o = st_r.dout;
	assign pixel_strobe_clock_out_o = st_r.rclk;
	assign lock_ok_o                = st_r.locked;
endmodule : psl_rx

`default_nettype wire

// file: tb/psl_link_assertions.sv
// Checker for the link carrier between the two ends of the serial pixel link.
// Sees only the carrier's signals plus the shared clock and reset.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module psl_link_assertions (
	// Clock and reset
	input wire logic                      clk_i,
	input wire logic                      rst_i,
	// Data lanes
	input wire logic [psl_pkg::LANES-1:0] serial_lane_pos,
	input wire logic [psl_pkg::LANES-1:0] serial_lane_neg,
	input wire logic                      serial_lane_oe,
	// Clock lane
	input wire logic                      forwarded_clock_pos,
	input wire logic                      forwarded_clock_neg,
	input wire logic                      forwarded_clock_oe
);
	// One domain, so one clock and one reset for all
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////////////////
	// Pairs stay complementary
	lane_mirror_a : assert property (serial_lane_neg == ~serial_lane_pos)
		else $error("Data lane complement differs from true side");
	clk_mirror_a : assert property (forwarded_clock_neg == ~forwarded_clock_pos)
		else $error("Clock lane complement differs from true side");
	// Four high slots then three low ones
	clk_shape_a : assert property ($rose(forwarded_clock_pos) |->
		forwarded_clock_pos [*4] ##1 !forwarded_clock_pos [*3])
		else $error("Forwarded clock frame shape wrong");
	// After seven slots: next frame or quiet lanes
	frame_end_a : assert property ($rose(forwarded_clock_pos) |->
		##7 (forwarded_clock_pos || serial_lane_pos == '0))
		else $error("Frame longer than seven slots");
	// Both drivers on whenever the link carries anything; a power-down may cut a frame
	frame_driven_a : assert property ((forwarded_clock_pos || serial_lane_pos != '0) |->
		(serial_lane_oe && forwarded_clock_oe))
		else $error("Lane driver off inside a frame");
	// Floated lanes carry nothing
	lanes_float_a : assert property (!serial_lane_oe [*3] |-> serial_lane_pos == '0)
		else $error("Data lanes active while floated");
	clk_float_a : assert property (!forwarded_clock_oe [*3] |-> !forwarded_clock_pos)
		else $error("Clock lane active while floated");
	// Idle link: clock stopped, lanes low
	lanes_idle_a : assert property (!forwarded_clock_pos [*4] |-> serial_lane_pos == '0)
		else $error("Data lanes busy while clock idle");

	////////////////////////////////////////////////////////////////////////////////
	// Main scenarios reached
	frame_c : cover property ($rose(forwarded_clock_pos));
	back_to_back_c : cover property ($rose(forwarded_clock_pos) ##7 $rose(forwarded_clock_pos));
	float_c : cover property ($fell(serial_lane_oe));
endmodule : psl_link_assertions

`default_nettype wire

// file: tb/pixel_serial_link_tx_rx_tb.sv
// Testbench for the serial pixel link: both ends joined over the link carrier.
// Assumes one shared 50 MHz clock; the bench makes the pixel clock itself.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module pixel_serial_link_tx_rx_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int LOCK = 20;                 // Short lock wait for simulation
	localparam int W    = psl_pkg::WORD_W;    // Parallel word width
	// Control lines, odd bits and dense patterns
	localparam logic [W-1:0] PATS [5] = '{28'h7000000, 28'h8800000, 28'hfffffff,
		28'h5555555, 28'haaaaaaa};

	logic         clk_i;                      // System clock
	logic         rst_i;                      // Synchronous reset
	logic         tx_pd_n;                    // Transmitter power-down, low active
	logic         rx_pd_n;                    // Receiver power-down, low active
	logic         pclk;                       // Pixel clock, stands high when idle
	logic         ready;                      // Transmit buffer has room
	logic [W-1:0] pix_in;                     // Word into the transmitter
	logic [W-1:0] pix_out;                    // Word out of the receiver
	logic         strobe;                     // Receiver strobe clock
	logic         strobe_q = 1'b0;            // Strobe at the previous sample
	logic         lock_ok;                    // Receiver lock flag
	logic [W-1:0] exp_q [$];                  // Words still due at the receiver
	bit           sent;                       // Last word really launched
	int           fails    = 0;
	int           compares = 0;
	int           rcvd     = 0;               // Words seen at the receiver
	int           hi       = 0;               // Strobe high time in cycles
	int           n;

	////////////////////////////////////////////////////////////////////////////////
	// Both ends face each other over one carrier
	psl_link_if i_psl_link_if ();

	psl_tx i_psl_tx (
		.clk_i                   (clk_i),
		.rst_i                   (rst_i),
		.power_down_n_i          (tx_pd_n),
		.pixel_strobe_clock_in_i (pclk),
		.parallel_pixel_inputs_i (pix_in),
		.pixel_ready_o           (ready),
		.link                    (i_psl_link_if.tx)
	);

	psl_rx #(.LOCK_CYCLES(LOCK)) i_psl_rx (
		.clk_i                    (clk_i),
		.rst_i                    (rst_i),
		.power_down_n_i           (rx_pd_n),
		.parallel_pixel_outputs_o (pix_out),
		.pixel_strobe_clock_out_o (strobe),
		.lock_ok_o                (lock_ok),
		.link                     (i_psl_link_if.rx)
	);

	psl_link_assertions i_psl_link_assertions (
		.clk_i               (clk_i),
		.rst_i               (rst_i),
		.serial_lane_pos     (i_psl_link_if.serial_lane_pos),
		.serial_lane_neg     (i_psl_link_if.serial_lane_neg),
		.serial_lane_oe      (i_psl_link_if.serial_lane_oe),
		.forwarded_clock_pos (i_psl_link_if.forwarded_clock_pos),
		.forwarded_clock_neg (i_psl_link_if.forwarded_clock_neg),
		.forwarded_clock_oe  (i_psl_link_if.forwarded_clock_oe)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Clock and watchdog
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// Whole run is well under 50 us; four times that means a hang
	initial
	begin
		#200us;
		fails++;
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Tasks
	task automatic check(input string what, input logic [W-1:0] want, input logic [W-1:0] got);
		compares++;
		if (got !== want)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, want, got);
		end
	endtask : check

	// One pixel: data with clock high, capture on the fall; skipped if the buffer is full
	task automatic send_pixel(input logic [W-1:0] w, input int half, input bit keep);
		@(negedge clk_i);
		sent = (ready === 1'b1);
		if (!sent)
			return;
		pix_in = w;
		repeat (half) @(negedge clk_i);
		pclk = 1'b0;
		if (keep)
			exp_q.push_back(w);
		repeat (half) @(negedge clk_i);
		pclk = 1'b1;
	endtask : send_pixel

	// Bounded wait until every queued word came out
	task automatic drain();
		n = 0;
		while (exp_q.size() != 0 && n < 3000)
		begin
			@(negedge clk_i);
			n++;
		end
		check("words left", 28'h0, 28'(exp_q.size()));
		repeat (12) @(negedge clk_i);
	endtask : drain

	task automatic wait_lock();
		n = 0;
		while (lock_ok !== 1'b1 && n < 200)
		begin
			@(negedge clk_i);
			n++;
		end
		check("lock wait", 28'h1, 28'(n >= LOCK - 2 && n <= LOCK + 8));
	endtask : wait_lock

	task automatic report_and_stop();
		$display("TB: %0d compares, %0d fails", compares, fails);
		if (fails == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////////////////////////////////////////////
	// Receiver monitor: word valid at the strobe's falling edge
	always @(negedge clk_i)
	begin
		if (strobe_q === 1'b1 && strobe === 1'b0)
		begin
			check("rx word", (exp_q.size() != 0) ? exp_q.pop_front() : 28'hx, pix_out);
			check("strobe high", 28'h3, 28'(hi));
			rcvd++;
		end
		hi = (strobe === 1'b1) ? hi + 1 : 0;
		strobe_q = strobe;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		rst_i   = 1'b1;
		tx_pd_n = 1'b1;
		rx_pd_n = 1'b1;
		pclk    = 1'b1;
		pix_in  = 28'h0;
		repeat (16) @(negedge clk_i);
		rst_i = 1'b0;
		check("rx word after reset", 28'h0, pix_out);
		check("strobe after reset", 28'h0, 28'(strobe));
		wait_lock();
		$display("TB: reset test done");

		// Every bit alone, then control lines and dense words
		for (int i = 0; i < W; i++)
			send_pixel(28'h1 << i, 4, 1'b1);
		foreach (PATS[i])
			send_pixel(PATS[i], 4, 1'b1);
		drain();
		$display("TB: bit map test done");

		// Pixel period cut to 100 ns so the buffer fills faster than the link drains
		n = 0;
		sent = 1'b1;
		while (sent && n < 300)
		begin
			send_pixel(28'(n * 28'h0123457), 2, 1'b1);
			n++;
		end
		check("buffer refused", 28'h0, 28'(sent));
		drain();
		check("room after drain", 28'h1, 28'(ready));
		$display("TB: buffer test done");

		// Transmitter power-down floats the link within 100 ns
		tx_pd_n = 1'b0;
		repeat (psl_pkg::TX_PD_CYCLES) @(negedge clk_i);
		check("tx float", 28'h0, 28'({i_psl_link_if.serial_lane_oe, i_psl_link_if.forwarded_clock_oe,
			i_psl_link_if.serial_lane_pos}));
		n = rcvd;
		send_pixel(28'h1234567, 4, 1'b0);
		repeat (20) @(negedge clk_i);
		check("words while tx down", 28'(n), 28'(rcvd));
		tx_pd_n = 1'b1;
		repeat (8) @(negedge clk_i);
		check("tx driven", 28'h3, 28'({i_psl_link_if.serial_lane_oe,
			i_psl_link_if.forwarded_clock_oe}));
		send_pixel(28'h0fedcba, 4, 1'b1);
		drain();
		$display("TB: tx power-down test done");

		// Receiver power-down holds its outputs and drops lock
		send_pixel(28'h0a5a5a5, 4, 1'b1);
		drain();
		rx_pd_n = 1'b0;
		repeat (psl_pkg::RX_PD_CYCLES) @(negedge clk_i);
		check("lock lost", 28'h0, 28'(lock_ok));
		n = rcvd;
		send_pixel(28'h05a5a5a, 4, 1'b0);
		repeat (20) @(negedge clk_i);
		check("rx held word", 28'h0a5a5a5, pix_out);
		check("words while rx down", 28'(n), 28'(rcvd));
		rx_pd_n = 1'b1;
		wait_lock();
		send_pixel(28'h1111111, 4, 1'b1);
		drain();
		$display("TB: rx power-down test done");
		report_and_stop();
	end
endmodule : pixel_serial_link_tx_rx_tb

`default_nettype wire
